/* rtl/output_loader_pkg.sv */
package output_loader_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] SHIFT_OFS = 8'h08;

  // Control register fields
  localparam int ALARM_THR_LSB = 0;
  localparam logic [7:0] ALARM_THR_RESET = 8'h8C;
  localparam logic [8:0] ALARM_HYST_DEG = 9'h014;

  // Status register field positions
  localparam int ST_STORAGE_LSB = 0;
  localparam int ST_ENABLE_LSB = 8;
  localparam int ST_ALARM_BIT = 16;
  localparam int ST_OVERHEAT_BIT = 17;
  localparam int ST_OVERCURRENT_BIT = 18;
  localparam int ST_MODE_BIT = 19;
  localparam int ST_STANDBY_BIT = 20;
  localparam int ST_GATE_BIT = 21;

  localparam int SYNC_STAGES = 2;
  localparam logic [7:0] STORAGE_RESET = 8'h00;
  localparam logic [7:0] SHIFT_RESET = 8'h00;

  // Pins that cross into the bus clock domain
  typedef struct packed {
    logic gate;
    logic standby_n;
    logic serial_interface_mode;
    logic latch;
    logic overheat_detect;
    logic overcurrent_detect;
    logic [7:0] direct_in;
  } pins_t;

  // Undriven levels: output permit high, all others low
  localparam pins_t PINS_RESET = '{gate: 1'b1, standby_n: 1'b0, serial_interface_mode: 1'b0,
                                   latch: 1'b0, overheat_detect: 1'b0, overcurrent_detect: 1'b0,
                                   direct_in: 8'h00};

  typedef struct packed {
    logic [9:0] spare;
    logic gate;
    logic standby_n;
    logic serial_interface_mode;
    logic overcurrent_shutdown;
    logic overheat_shutdown;
    logic thermal_alarm;
    logic [7:0] output_en;
    logic [7:0] storage;
  } status_t;

endpackage

/* rtl/serial_output_enable_loader.sv */
`timescale 1ns/100ps
`default_nettype none

module serial_output_enable_loader #(
  parameter int WIDTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sclk,
  input wire logic serial_data,
  input wire logic latch,
  input wire logic storage_clear_n,
  input wire logic gate,
  input wire logic standby_n,
  input wire logic serial_interface_mode,
  input wire logic [WIDTH-1:0] direct_in,
  input wire logic overheat_detect,
  input wire logic overcurrent_detect,
  input wire logic [7:0] chip_temp,
  output logic [WIDTH-1:0] output_en,
  output logic thermal_warn_n_o,
  output logic thermal_warn_n_oe
);

  output_loader_pkg::pins_t pins_in;
  output_loader_pkg::pins_t pins_meta_r;
  output_loader_pkg::pins_t pins_s_r;
  logic [WIDTH-1:0] shift_r;
  logic [WIDTH-1:0] shift_meta_r;
  logic [WIDTH-1:0] shift_s_r;
  logic latch_prev_r;
  logic latch_rise;
  logic [WIDTH-1:0] storage_r;
  logic [WIDTH-1:0] enable_nxt;
  logic overheat_shutdown;
  logic overcurrent_shutdown;
  logic thermal_alarm_r;
  logic [7:0] alarm_thr_r;
  logic addr_ok;
  logic wr_pend_r;
  logic [7:0] wr_ofs_r;
  output_loader_pkg::status_t status;

  function automatic logic [31:0] read_mux(input logic [7:0] ofs, input output_loader_pkg::status_t st,
                                           input logic [7:0] thr, input logic [WIDTH-1:0] sh);
    logic [31:0] val;
    val = 32'h0000_0000;
    case (ofs)
      output_loader_pkg::CTRL_OFS: val[7:0] = thr;
      output_loader_pkg::STATUS_OFS: val = 32'(st);
      output_loader_pkg::SHIFT_OFS: val[WIDTH-1:0] = sh;
      default: val = 32'h0000_0000;
    endcase
    return val;
  endfunction

  // ---------------- Link domain: shift register on the serial clock ----------------
  // Data and clear are set up by the controller around the clock edge, so they are
  // sampled directly; a synchroniser here would need extra edges the link never gives.
  always_ff @(posedge sclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_r <= output_loader_pkg::SHIFT_RESET;
    end else if (storage_clear_n) begin
      shift_r <= {shift_r[WIDTH-2:0], serial_data};
    end
  end
  // Only rising edges of sclk touch the shift register.

  // ---------------- Bus domain: pin synchronisers ----------------
  assign pins_in = '{gate: gate, standby_n: standby_n, serial_interface_mode: serial_interface_mode,
                     latch: latch, overheat_detect: overheat_detect,
                     overcurrent_detect: overcurrent_detect, direct_in: direct_in};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_meta_r <= output_loader_pkg::PINS_RESET;
      pins_s_r <= output_loader_pkg::PINS_RESET;
    end else begin
      pins_meta_r <= pins_in;
      pins_s_r <= pins_meta_r;
    end
  end

  // The shift word is quasi-static when the latch rises (serial clock parked low),
  // so per-bit two-stage sync matches the latch sync latency and is coherent.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_meta_r <= output_loader_pkg::SHIFT_RESET;
      shift_s_r <= output_loader_pkg::SHIFT_RESET;
    end else begin
      shift_meta_r <= shift_r;
      shift_s_r <= shift_meta_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_prev_r <= 1'b0;
    end else begin
      latch_prev_r <= pins_s_r.latch;
    end
  end

  assign latch_rise = pins_s_r.latch && !latch_prev_r;

  // ---------------- Storage register ----------------
  // Clear acts without the clock, like the device's own asynchronous clear.
  always_ff @(posedge hclk or negedge hresetn or negedge storage_clear_n) begin
    if (!hresetn || !storage_clear_n) begin
      storage_r <= output_loader_pkg::STORAGE_RESET;
    end else if (latch_rise) begin
      storage_r <= shift_s_r;
    end
  end
  // Falling latch edges are ignored by the edge detector.

  a_clear_storage: assert property (@(posedge hclk) disable iff (!hresetn)
    !storage_clear_n |-> storage_r == '0) else $error("storage not cleared while clear low");

  a_latch_copies: assert property (@(posedge hclk) disable iff (!hresetn)
    (pins_s_r.latch && !latch_prev_r && storage_clear_n) ##1 storage_clear_n
      |-> storage_r == $past(shift_s_r)) else $error("latch rise did not copy shift word");

  a_storage_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    (!(pins_s_r.latch && !latch_prev_r) && storage_clear_n) ##1 storage_clear_n
      |-> $stable(storage_r)) else $error("storage changed without latch rise");

  a_shift_step: assert property (@(posedge sclk) disable iff (!hresetn)
    storage_clear_n |=> shift_r == {$past(shift_r[WIDTH-2:0]), $past(serial_data)})
    else $error("shift register did not advance");

  // ---------------- Latched protection shutdowns ----------------
  // A detection in the same cycle as standby wins, so a live fault is never lost.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overheat_shutdown <= 1'b0;
      overcurrent_shutdown <= 1'b0;
    end else begin
      if (pins_s_r.overheat_detect) begin
        overheat_shutdown <= 1'b1;
      end else if (!pins_s_r.standby_n) begin
        overheat_shutdown <= 1'b0;
      end
      if (pins_s_r.overcurrent_detect) begin
        overcurrent_shutdown <= 1'b1;
      end else if (!pins_s_r.standby_n) begin
        overcurrent_shutdown <= 1'b0;
      end
    end
  end

  a_standby_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    (!pins_s_r.standby_n && !pins_s_r.overheat_detect) |=> !overheat_shutdown)
    else $error("standby did not clear overheat shutdown");

  // ---------------- Output enables ----------------
  always_comb begin
    enable_nxt = '0;
    if (pins_s_r.standby_n && !overheat_shutdown && !overcurrent_shutdown) begin
      if (!pins_s_r.serial_interface_mode) begin
        enable_nxt = pins_s_r.direct_in;
      end else if (pins_s_r.gate) begin
        enable_nxt = storage_r;
      end else begin
        enable_nxt = '0;
      end
    end
  end

  // High turns the channel's transistor on, low leaves the output floating.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_en <= '0;
    end else begin
      output_en <= enable_nxt;
    end
  end

  a_gate_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
    (pins_s_r.serial_interface_mode && !pins_s_r.gate) |=> output_en == '0)
    else $error("enables active while permit low");

  a_gate_passes: assert property (@(posedge hclk) disable iff (!hresetn)
    (pins_s_r.serial_interface_mode && pins_s_r.gate && pins_s_r.standby_n
     && !overheat_shutdown && !overcurrent_shutdown) |=> output_en == $past(storage_r))
    else $error("enables do not follow storage register");

  a_standby_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !pins_s_r.standby_n [*2] |-> output_en == '0) else $error("outputs on during standby");

  // ---------------- Thermal alarm with hysteresis ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thermal_alarm_r <= 1'b0;
    end else if (chip_temp >= alarm_thr_r) begin
      thermal_alarm_r <= 1'b1;
    end else if ({1'b0, chip_temp} + output_loader_pkg::ALARM_HYST_DEG <= {1'b0, alarm_thr_r}) begin
      thermal_alarm_r <= 1'b0;
    end
  end

  // Open drain: only ever pulls low, and only in serial mode.
  assign thermal_warn_n_o = 1'b0;
  assign thermal_warn_n_oe = thermal_alarm_r && pins_s_r.serial_interface_mode;

  a_alarm_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    (chip_temp >= alarm_thr_r && pins_s_r.serial_interface_mode)
      ##1 pins_s_r.serial_interface_mode |-> thermal_warn_n_oe)
    else $error("alarm not driven at threshold");

  a_alarm_hyst: assert property (@(posedge hclk) disable iff (!hresetn)
    (thermal_alarm_r && {1'b0, chip_temp} + output_loader_pkg::ALARM_HYST_DEG > {1'b0, alarm_thr_r})
      |=> thermal_alarm_r) else $error("alarm released inside hysteresis band");

  a_alarm_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    !pins_s_r.serial_interface_mode |-> !thermal_warn_n_oe) else $error("alarm driven outside serial mode");

  // ---------------- Further guards on stage, storage and enables ----------------
  // While clear is low the link stages freeze, so a frame sent then is simply lost.
  a_shift_frozen: assert property (@(posedge sclk) disable iff (!hresetn)
    !storage_clear_n |=> $stable(shift_r))
    else $error("shift register moved while clear low");

  // A falling latch edge on its own must never disturb the stored word.
  a_latch_fall: assert property (@(posedge hclk) disable iff (!hresetn)
    (!pins_s_r.latch && latch_prev_r && storage_clear_n) ##1 storage_clear_n
      |-> $stable(storage_r))
    else $error("storage changed on latch fall");

  a_direct_pass: assert property (@(posedge hclk) disable iff (!hresetn)
    (!pins_s_r.serial_interface_mode && pins_s_r.standby_n
     && !overheat_shutdown && !overcurrent_shutdown)
      |=> output_en == $past(pins_s_r.direct_in))
    else $error("direct enables not applied");

  // Either latched shutdown wins over both modes and over the gate.
  a_shutdown_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (overheat_shutdown || overcurrent_shutdown) |=> output_en == '0)
    else $error("enables active during shutdown");

  a_overheat_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    pins_s_r.overheat_detect |=> overheat_shutdown)
    else $error("overheat detection not latched");

  a_overcur_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    pins_s_r.overcurrent_detect |=> overcurrent_shutdown)
    else $error("overcurrent detection not latched");

  a_overcur_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (!pins_s_r.standby_n && !pins_s_r.overcurrent_detect) |=> !overcurrent_shutdown)
    else $error("standby did not clear overcurrent shutdown");

  // The latch only lets go through standby or a full reset, never by itself.
  a_overheat_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    (overheat_shutdown && pins_s_r.standby_n) |=> overheat_shutdown)
    else $error("overheat shutdown released without standby");

  a_overcur_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    (overcurrent_shutdown && pins_s_r.standby_n) |=> overcurrent_shutdown)
    else $error("overcurrent shutdown released without standby");

  // ---------------- Further guards on the thermal alarm ----------------
  a_alarm_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (!thermal_alarm_r && chip_temp < alarm_thr_r) |=> !thermal_alarm_r)
    else $error("alarm raised below threshold");

  // Release needs the full band below the threshold, not just a drop under it.
  a_alarm_release: assert property (@(posedge hclk) disable iff (!hresetn)
    (thermal_alarm_r && chip_temp < alarm_thr_r
     && {1'b0, chip_temp} + output_loader_pkg::ALARM_HYST_DEG <= {1'b0, alarm_thr_r})
      |=> !thermal_alarm_r)
    else $error("alarm did not release below band");

  a_alarm_serial: assert property (@(posedge hclk) disable iff (!hresetn)
    (thermal_alarm_r && pins_s_r.serial_interface_mode) |-> thermal_warn_n_oe)
    else $error("alarm not driven in serial mode");

  // ---------------- AHB-Lite slave ----------------
  // Zero wait states: read data is fetched in the address phase and held in a flop.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && htrans[1] && hready;

  assign status = '{spare: '0, gate: pins_s_r.gate, standby_n: pins_s_r.standby_n,
                    serial_interface_mode: pins_s_r.serial_interface_mode,
                    overcurrent_shutdown: overcurrent_shutdown, overheat_shutdown: overheat_shutdown,
                    thermal_alarm: thermal_alarm_r, output_en: output_en, storage: storage_r};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= addr_ok && hwrite;
      wr_ofs_r <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= read_mux(haddr[7:0], status, alarm_thr_r, shift_s_r);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_thr_r <= output_loader_pkg::ALARM_THR_RESET;
    end else if (wr_pend_r && wr_ofs_r == output_loader_pkg::CTRL_OFS) begin
      alarm_thr_r <= hwdata[output_loader_pkg::ALARM_THR_LSB +: 8];
    end
  end

  // ---------------- Guards on the register bus ----------------
  // A threshold write lands on the edge that ends its data phase.
  a_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && wr_ofs_r == output_loader_pkg::CTRL_OFS)
      |=> alarm_thr_r == $past(hwdata[output_loader_pkg::ALARM_THR_LSB +: 8]))
    else $error("threshold write did not land");

  // The shift word read back is the synchronised copy, taken at the address phase.
  a_shift_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && haddr[7:0] == output_loader_pkg::SHIFT_OFS)
      |=> hrdata[WIDTH-1:0] == $past(shift_s_r))
    else $error("shift word read back wrong");

  a_status_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && haddr[7:0] == output_loader_pkg::STATUS_OFS)
      |=> hrdata[WIDTH-1:0] == $past(storage_r))
    else $error("storage word read back wrong");

  // Reads leave the threshold register alone; only the pending write path changes it.
  a_read_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && !wr_pend_r) |=> $stable(alarm_thr_r))
    else $error("threshold changed on a read");

endmodule

`default_nettype wire

/* testbench/host_serial_model.sv */
`timescale 1ns/100ps
`default_nettype none

module host_serial_model (
  output logic sclk,
  output logic serial_data,
  output logic latch
);
  initial begin
    sclk = 1'h0;
    serial_data = 1'h0;
    latch = 1'h0;
  end

  // Link clock of 125 ns runs only within a frame, so it drifts against the bus clock
  task automatic send_byte(input logic [7:0] w, input logic do_latch);
    for (int i = 7; i >= 0; i--) begin
      serial_data = w[i];
      #62.5 sclk = 1'h1;
      #62.5 sclk = 1'h0;
    end
    // Data line toggles after the frame so a stale level is never mistaken for a shift
    serial_data = ~serial_data;
    if (do_latch) begin
      #125 latch = 1'h1;
      #125 latch = 1'h0;
    end
  endtask
endmodule

`default_nettype wire

/* testbench/serial_output_enable_loader_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module serial_output_enable_loader_tb_top;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic sclk, serial_data, latch;
  logic storage_clear_n = 1'h1;
  logic gate = 1'h1;
  logic standby_n = 1'h1;
  logic serial_interface_mode = 1'h1;
  logic [7:0] direct_in = 8'h00;
  logic overheat_detect = 1'h0;
  logic overcurrent_detect = 1'h0;
  logic [7:0] chip_temp = 8'h19;
  logic [7:0] output_en;
  logic thermal_warn_n_o, thermal_warn_n_oe;
  logic [31:0] q;
  int fails = 0;
  int cmp_count = 0;
  int tmo = 0;

  serial_output_enable_loader i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .sclk(sclk), .serial_data(serial_data),
    .latch(latch), .storage_clear_n(storage_clear_n), .gate(gate), .standby_n(standby_n),
    .serial_interface_mode(serial_interface_mode), .direct_in(direct_in),
    .overheat_detect(overheat_detect), .overcurrent_detect(overcurrent_detect), .chip_temp(chip_temp),
    .output_en(output_en), .thermal_warn_n_o(thermal_warn_n_o), .thermal_warn_n_oe(thermal_warn_n_oe));

  host_serial_model i_host (.sclk(sclk), .serial_data(serial_data), .latch(latch));

  always #5 hclk = ~hclk;

  always @(posedge hclk) begin
    tmo++;
    if (tmo == 6000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'h0, a, 32'h0, q);
    chk(q, exp);
  endtask

  // Enables settle three bus clocks after a gate, standby, mode or direct pin change, four after a latch or detect pin; eight leaves margin
  task automatic wait_en(input logic [7:0] exp);
    repeat (8) @(posedge hclk);
    chk({24'h0, output_en}, {24'h0, exp});
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    wait_en(8'h00);
    chk({31'h0, thermal_warn_n_oe}, 32'h0);
    chk({31'h0, thermal_warn_n_o}, 32'h0);
    rd_chk({24'h0, output_loader_pkg::CTRL_OFS}, {24'h0, output_loader_pkg::ALARM_THR_RESET});
    rd_chk(32'h0000000C, 32'h0);
    i_host.send_byte(8'hA5, 1'h1);
    wait_en(8'hA5);
    rd_chk({24'h0, output_loader_pkg::SHIFT_OFS}, 32'h000000A5);
    @(posedge hclk) gate <= 1'h0;
    wait_en(8'h00);
    @(posedge hclk) gate <= 1'h1;
    wait_en(8'hA5);
    @(posedge hclk) standby_n <= 1'h0;
    wait_en(8'h00);
    @(posedge hclk) standby_n <= 1'h1;
    wait_en(8'hA5);
    for (int k = 0; k < 2; k++) begin
      @(posedge hclk);
      overheat_detect <= (k == 0);
      overcurrent_detect <= (k == 1);
      wait_en(8'h00);
      @(posedge hclk);
      overheat_detect <= 1'h0;
      overcurrent_detect <= 1'h0;
      wait_en(8'h00);
      rd_chk({24'h0, output_loader_pkg::STATUS_OFS}, 32'h003800A5 | (32'h00020000 << k));
      @(posedge hclk) standby_n <= 1'h0;
      repeat (8) @(posedge hclk);
      standby_n <= 1'h1;
      wait_en(8'hA5);
    end
    i_host.send_byte(8'h3C, 1'h1);
    wait_en(8'h3C);
    i_host.send_byte(8'hC3, 1'h0);
    wait_en(8'h3C);
    @(posedge hclk) storage_clear_n <= 1'h0;
    wait_en(8'h00);
    i_host.send_byte(8'hFF, 1'h1);
    @(posedge hclk) storage_clear_n <= 1'h1;
    wait_en(8'h00);
    rd_chk({24'h0, output_loader_pkg::SHIFT_OFS}, 32'h000000C3);
    ahb(1'h1, {24'h0, output_loader_pkg::CTRL_OFS}, 32'h00000050, q);
    @(posedge hclk) chip_temp <= 8'h50;
    wait_en(8'h00);
    chk({31'h0, thermal_warn_n_oe}, 32'h1);
    @(posedge hclk) chip_temp <= 8'h3D;
    wait_en(8'h00);
    chk({31'h0, thermal_warn_n_oe}, 32'h1);
    @(posedge hclk) chip_temp <= 8'h3C;
    wait_en(8'h00);
    chk({31'h0, thermal_warn_n_oe}, 32'h0);
    // Hot again but in direct mode: alarm sets but its output must stay undriven while direct enables pass
    @(posedge hclk);
    chip_temp <= 8'h50;
    serial_interface_mode <= 1'h0;
    direct_in <= 8'h81;
    wait_en(8'h81);
    chk({31'h0, thermal_warn_n_oe}, 32'h0);
    report_and_stop();
  end
endmodule

`default_nettype wire
